/* rtl/jlc_config_select.sv */
// JESD204B link configuration selector and checker with an APB slave
//
// Functional notes
// - Output rate is sample clock over decimation.
// - Lane rate, clock and LCM limits hold.
// - Only listed decimations per combination and band.
// - Resolution 8 to 16, 0-3 control bits.
// - Eight converters: listed lane/octet pairs only.
// - Four converters: listed lane/octet pairs only.
// - One or two samples per frame.
// - High density only with one octet.
// - Lane rate = M x 20 x fout / L.
// - K times F divisible by four.
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "jlc_map.svh"

module jlc_config_select import jlc_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Datapath side
  output logic out_sample_en,
  output logic link_enable,
  output logic config_error
);

  jlc_state_t s;
  jlc_state_t next_s;

  // Allowed decimations, bit d set for ratio d
  function automatic logic [63:0] decim_mask(input logic m8,
      input logic [1:0] li, input logic [1:0] band);
    logic [63:0] m;
    m = '0;
    case ({m8, li, band})
      5'h00: m = `JLC_DM_G;
      5'h01: m = `JLC_DM_H;
      5'h02: m = `JLC_DM_I;
      5'h03: m = `JLC_DM_J;
      5'h04: m = `JLC_DM_A;
      5'h05: m = `JLC_DM_B;
      5'h06: m = `JLC_DM_C;
      5'h07: m = `JLC_DM_D;
      5'h08: m = `JLC_DM_B;
      5'h09: m = `JLC_DM_C;
      5'h0A: m = `JLC_DM_D;
      5'h0B: m = `JLC_DM_E;
      5'h0C: m = `JLC_DM_C;
      5'h0D: m = `JLC_DM_D;
      5'h0E: m = `JLC_DM_E;
      5'h0F: m = `JLC_DM_F;
      5'h10: m = `JLC_DM_K;
      5'h11: m = `JLC_DM_L;
      5'h12: m = `JLC_DM_M;
      5'h13: m = `JLC_DM_N;
      5'h14: m = `JLC_DM_L;
      5'h15: m = `JLC_DM_O;
      5'h16: m = `JLC_DM_P;
      5'h17: m = `JLC_DM_J;
      5'h18: m = `JLC_DM_O;
      5'h19: m = `JLC_DM_P;
      5'h1A: m = `JLC_DM_J;
      5'h1B: m = `JLC_DM_Q;
      5'h1C: m = `JLC_DM_P;
      5'h1D: m = `JLC_DM_J;
      5'h1E: m = `JLC_DM_Q;
      5'h1F: m = `JLC_DM_R;
    endcase
    return m;
  endfunction

  logic [31:0] lanes32;
  logic [31:0] convs32;
  logic [31:0] decim32;
  logic [31:0] num2;
  logic [31:0] den;
  logic [1:0] lane_idx;
  logic [1:0] band;
  logic lanes_ok;
  logic [63:0] mask;
  jlc_err_t err;
  logic setup;
  logic access;
  logic mapped;
  logic [31:0] rd;

  always_comb begin
    lanes32 = {28'h0, s.link.lanes};
    convs32 = {28'h0, s.link.convs};
    decim32 = {26'h0, s.decimation_ratio};
    // Half-Mbps lane rate times dcm*L, so no divider is needed
    num2 = `JLC_RATE_FACTOR * convs32 * {16'h0, s.clk_mhz};
    den = decim32 * lanes32;
    lane_idx = 2'h0;
    lanes_ok = 1'b1;
    case (s.link.lanes)
      4'h1: lane_idx = 2'h0;
      4'h2: lane_idx = 2'h1;
      4'h4: lane_idx = 2'h2;
      4'h8: lane_idx = 2'h3;
      default: lanes_ok = 1'b0;
    endcase
    if (num2 > `JLC_HALF_MBPS_B3 * den) begin
      band = 2'h3;
    end else if (num2 >= `JLC_HALF_MBPS_B2 * den) begin
      band = 2'h2;
    end else if (num2 >= `JLC_HALF_MBPS_B1 * den) begin
      band = 2'h1;
    end else begin
      band = 2'h0;
    end
    // Only four and eight converters carry decimation tables
    err.param_err = !lanes_ok
        || !(s.link.convs == 4'h4 || s.link.convs == 4'h8)
        || ({27'h0, s.link.octets} * lanes32
            != 32'h2 * convs32 * {28'h0, s.link.samples})
        || !(s.link.samples == 4'h1 || s.link.samples == 4'h2)
        || (s.link.high_density_packing
            != (s.link.octets == 5'h01));
    err.rate_err = (s.decimation_ratio == 6'h00)
        || (num2 < `JLC_HALF_MBPS_MIN * den)
        || (num2 > `JLC_HALF_MBPS_MAX * den)
        || (convs32 > `JLC_CLK_PER_LANE * den)
        || ((den & (convs32 - 32'h1)) != 32'h0)
        || (lanes32 >= convs32 && den > `JLC_LCM_MAX * convs32);
    mask = decim_mask(s.link.convs[3], lane_idx, band);
    err.decim_err = !mask[s.decimation_ratio];
    // Range setting belongs to software; a mismatch is refused here
    err.range_err = (band == 2'h3 && s.range_set != `JLC_RANGE_TOP)
        || (band == 2'h2 && s.range_set != `JLC_RANGE_MID);
    err.format_err = (s.word.res < `JLC_RES_MIN)
        || (s.word.res > `JLC_WORD_BITS)
        || ({3'h0, s.word.res} + {6'h0, s.word.ctrl_bits}
            > {3'h0, `JLC_WORD_BITS})
        || (s.word.frames == 6'h00 || s.word.frames > `JLC_K_MAX)
        || (((s.word.frames * {1'b0, s.link.octets}) & 6'h03) != 6'h00)
        || (s.link.octets == 5'h01 && s.word.frames < `JLC_K_MIN_F1);

    setup = psel && !penable;
    access = psel && penable && s.ready;
    mapped = 1'b1;
    rd = 32'h0;
    case (paddr)
      `JLC_OFF_CTRL: rd = {31'h0, s.start};
      `JLC_OFF_LINK: rd = {11'h0, s.link.high_density_packing,
          s.link.samples, 3'h0, s.link.octets, s.link.convs, s.link.lanes};
      `JLC_OFF_WORD: rd = {10'h0, s.word.frames, 6'h0, s.word.ctrl_bits,
          3'h0, s.word.res};
      `JLC_OFF_DECIM: rd = {26'h0, s.decimation_ratio};
      `JLC_OFF_CLK: rd = {16'h0, s.clk_mhz};
      `JLC_OFF_RANGE: rd = {24'h0, s.range_set};
      `JLC_OFF_STATUS: rd = {19'h0, s.err, 2'h0, s.band, 2'h0,
          s.active, !s.cfg_err};
      default: mapped = 1'b0;
    endcase

    next_s = s;
    next_s.ready = setup;
    next_s.slverr = setup && !mapped;
    if (setup) begin
      next_s.rdata = (mapped && !pwrite) ? rd : 32'h0;
    end
    if (access && pwrite && !s.slverr) begin
      case (paddr)
        `JLC_OFF_CTRL: next_s.start = pwdata[0];
        `JLC_OFF_LINK: begin
          next_s.link.lanes = pwdata[`JLC_LINK_L_LSB +: 4];
          next_s.link.convs = pwdata[`JLC_LINK_M_LSB +: 4];
          next_s.link.octets = pwdata[`JLC_LINK_F_LSB +: 5];
          next_s.link.samples = pwdata[`JLC_LINK_S_LSB +: 4];
          next_s.link.high_density_packing = pwdata[`JLC_LINK_DENSE_BIT];
        end
        `JLC_OFF_WORD: begin
          next_s.word.res = pwdata[`JLC_WORD_N_LSB +: 5];
          next_s.word.ctrl_bits = pwdata[`JLC_WORD_CS_LSB +: 2];
          next_s.word.frames = pwdata[`JLC_WORD_K_LSB +: 6];
        end
        `JLC_OFF_DECIM: next_s.decimation_ratio = pwdata[5:0];
        `JLC_OFF_CLK: next_s.clk_mhz = pwdata[15:0];
        `JLC_OFF_RANGE: next_s.range_set = pwdata[7:0];
        default: next_s.start = s.start;
      endcase
    end

    next_s.err = err;
    next_s.band = band;
    next_s.cfg_err = |err;
    next_s.active = s.start && !s.cfg_err && !(|err);
    // Output-rate strobe: one pulse per decimation period
    if (s.decimation_ratio == 6'h00
        || s.div_cnt + 6'h01 >= s.decimation_ratio) begin
      next_s.div_cnt = 6'h00;
      next_s.sample_en = (s.decimation_ratio != 6'h00);
    end else begin
      next_s.div_cnt = s.div_cnt + 6'h01;
      next_s.sample_en = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      s.link.lanes <= `JLC_RST_L;
      s.link.convs <= `JLC_RST_M;
      s.link.octets <= `JLC_RST_F;
      s.link.samples <= `JLC_RST_S;
      s.word.res <= `JLC_RST_N;
      s.word.frames <= `JLC_RST_K;
      s.decimation_ratio <= `JLC_RST_DECIM;
      s.clk_mhz <= `JLC_RST_CLK_MHZ;
      s.range_set <= `JLC_RST_RANGE;
      s.cfg_err <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.slverr;
  assign out_sample_en = s.sample_en;
  assign link_enable = s.active;
  assign config_error = s.cfg_err;
endmodule // jlc_config_select

/* rtl/jlc_map.svh */
// Register map, field positions, limits and decimation masks of the link selector
`ifndef JLC_MAP_SVH
`define JLC_MAP_SVH
`define JLC_OFF_CTRL 8'h00
`define JLC_OFF_LINK 8'h04
`define JLC_OFF_WORD 8'h08
`define JLC_OFF_DECIM 8'h0C
`define JLC_OFF_CLK 8'h10
`define JLC_OFF_RANGE 8'h14
`define JLC_OFF_STATUS 8'h18
`define JLC_LINK_L_LSB 0
`define JLC_LINK_M_LSB 4
`define JLC_LINK_F_LSB 8
`define JLC_LINK_S_LSB 16
`define JLC_LINK_DENSE_BIT 20
`define JLC_WORD_N_LSB 0
`define JLC_WORD_CS_LSB 8
`define JLC_WORD_K_LSB 16
`define JLC_ST_BAND_LSB 4
`define JLC_ST_ERR_LSB 8
`define JLC_RST_L 4'h8
`define JLC_RST_M 4'h8
`define JLC_RST_F 5'h02
`define JLC_RST_S 4'h1
`define JLC_RST_N 5'h10
`define JLC_RST_K 6'h20
`define JLC_RST_DECIM 6'h04
`define JLC_RST_CLK_MHZ 16'h0BB8
`define JLC_RST_RANGE 8'h30
`define JLC_RANGE_TOP 8'h30
`define JLC_RANGE_MID 8'h10
`define JLC_WORD_BITS 5'h10
`define JLC_RES_MIN 5'h08
`define JLC_CS_MAX 2'h3
`define JLC_K_MAX 6'h20
`define JLC_K_MIN_F1 6'h14
`define JLC_LCM_MAX 32'h40
// Lane-rate figures in half-Mbps, so that 1687.5 Mbps stays whole
`define JLC_HALF_MBPS_MIN 32'h00000D2F
`define JLC_HALF_MBPS_B1 32'h00001A5E
`define JLC_HALF_MBPS_B2 32'h000034BC
`define JLC_HALF_MBPS_B3 32'h00006978
`define JLC_HALF_MBPS_MAX 32'h00007918
// Twice the 20x lane-rate factor of a 16-bit word with 8b/10b coding
`define JLC_RATE_FACTOR 32'h00000028
`define JLC_CLK_PER_LANE 32'h00000002
`define JLC_DM_A 64'h0001_0100_4111_9510
`define JLC_DM_B 64'h0000_0000_4111_9574
`define JLC_DM_C 64'h0000_0000_0001_957E
`define JLC_DM_D 64'h0000_0000_0000_017E
`define JLC_DM_E 64'h0000_0000_0000_001E
`define JLC_DM_F 64'h0000_0000_0000_0006
`define JLC_DM_G 64'h0001_0100_4111_0100
`define JLC_DM_H 64'h0001_0100_4111_1510
`define JLC_DM_I 64'h0000_0000_4111_1554
`define JLC_DM_J 64'h0000_0000_0001_1554
`define JLC_DM_K 64'h0001_0100_0001_0000
`define JLC_DM_L 64'h0001_0100_0111_0100
`define JLC_DM_M 64'h0001_0100_0111_1110
`define JLC_DM_N 64'h0000_0000_0111_1110
`define JLC_DM_O 64'h0001_0100_0111_1510
`define JLC_DM_P 64'h0000_0000_0111_1554
`define JLC_DM_Q 64'h0000_0000_0000_0154
`define JLC_DM_R 64'h0000_0000_0000_0014
`endif

/* rtl/jlc_pkg.sv */
// Types shared by the link configuration selector
package jlc_pkg;
  typedef struct packed {
    logic high_density_packing;
    logic [3:0] samples;
    logic [4:0] octets;
    logic [3:0] convs;
    logic [3:0] lanes;
  } jlc_link_t;

  typedef struct packed {
    logic [5:0] frames;
    logic [1:0] ctrl_bits;
    logic [4:0] res;
  } jlc_word_t;

  typedef struct packed {
    logic format_err;
    logic range_err;
    logic decim_err;
    logic rate_err;
    logic param_err;
  } jlc_err_t;

  typedef struct packed {
    jlc_link_t link;
    jlc_word_t word;
    logic [5:0] decimation_ratio;
    logic [15:0] clk_mhz;
    logic [7:0] range_set;
    logic start;
    jlc_err_t err;
    logic [1:0] band;
    logic [5:0] div_cnt;
    logic sample_en;
    logic active;
    logic cfg_err;
    logic ready;
    logic slverr;
    logic [31:0] rdata;
  } jlc_state_t;
endpackage

/* verification/jlc_config_select_chk.sv */
// Port-level assertions for the link configuration selector
`timescale 1ns/1ps
module jlc_config_select_chk import jlc_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Datapath side
  input wire logic out_sample_en,
  input wire logic link_enable,
  input wire logic config_error
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable && pready; endsequence
  property p_ready_next; s_setup |=> s_access; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready");
  property p_ready_cause; pready |-> s_access ##0 $past(psel && !penable);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("stray ready");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("long ready");
  property p_slv_map;
    pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h18);
  endproperty
  a_slv_map: assert property (p_slv_map) else $error("bad slverr");
  property p_rdata_hold; !pready |-> $stable(prdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  property p_after_rst;
    $fell(rst) |-> config_error && !link_enable && !pready;
  endproperty
  a_after_rst: assert property (p_after_rst) else $error("reset state");
  property p_err_blocks; config_error |=> !link_enable; endproperty
  a_err_blocks: assert property (p_err_blocks) else $error("link on err");
  property p_link_cause;
    $rose(link_enable) |-> !config_error && $past(!config_error);
  endproperty
  a_link_cause: assert property (p_link_cause) else $error("link early");
  property p_strobe; out_sample_en |=> !out_sample_en; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe width");
endmodule // jlc_config_select_chk

/* verification/jlc_rx_model.sv */
// Behavioural link receiver counting output-rate strobes
`timescale 1ns/1ps
module jlc_rx_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // From the selector
  input wire logic link_enable,
  input wire logic out_sample_en,
  // Samples taken
  output logic [15:0] seen
);
  // Nothing is taken before the link is up
  always_ff @(posedge clock) begin
    if (rst) begin
      seen <= 16'h0000;
    end else if (link_enable && out_sample_en) begin
      seen <= seen + 16'h0001;
    end
  end
endmodule // jlc_rx_model

/* verification/jlc_config_select_test.sv */
// Self-checking bench for the link configuration selector
`timescale 1ns/1ps
`include "jlc_map.svh"
module jlc_config_select_test import jlc_pkg::*; ;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic sl;
  wire [31:0] prdata;
  wire pready, pslverr, out_sample_en, link_enable, config_error;
  wire [15:0] seen;
  int err_count = 0, compares = 0, cyc = 0;
  int cl[8] = '{337, 338, 1349, 1350, 2700, 2701, 3100, 3101};
  logic [31:0] rv[5] = '{32'h1_0288, 32'h20_0010, 32'h4, 32'hBB8, 32'h30};
  logic [7:0] ta[8] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h08};
  logic [31:0] tv[8] = '{32'h11_0288, 32'h3_0288, 32'h1_0282, 32'h2_0488,
    32'h20_0007, 32'h20_0110, 32'h1F_0010, 32'h20_020E};
  logic te[8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  always #12.5 clock = ~clock;
  jlc_config_select jlc_config_select_inst (.clock, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .out_sample_en,
    .link_enable, .config_error);
  jlc_rx_model jlc_rx_model_inst (.clock, .rst, .link_enable,
    .out_sample_en, .seen);
  task give_verdict;
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Idle cycle first, so a release is never re-driven in the same step
  // Waits for ready without a limit; the cycle ceiling ends a hang
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    sl = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task per(input int d);
    int n, k;
    for (k = 0; k < 2; k++) begin
      n = 0;
      do begin @(posedge clock); n++; end
      while (out_sample_en !== 1'b1 && n < 64);
    end
    chk(n, d);
  endtask
  // Eight converters, eight lanes, decimation 4: lane rate is 5x clock
  function automatic logic [2:0] exp_st(input int c, input int r);
    int lr;
    logic [1:0] b;
    lr = 5 * c;
    b = lr < 3375 ? 2'h0 : lr < 6750 ? 2'h1 : lr <= 13500 ? 2'h2 : 2'h3;
    return {2 * lr < 3375 || lr > 15500 || (b == 2'h3 && r != 32'h30) ||
      (b == 2'h2 && r != 32'h10), b};
  endfunction
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    int i, c, r;
    logic [2:0] e;
    logic [15:0] s0;
    void'($urandom(32'h699B));
    repeat (3) @(posedge clock);
    chk(config_error, 1'b1);
    rst <= 1'b0;
    for (i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i + 4), 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk(sl, 1'b1);
    for (i = 0; i < 24; i++) begin
      c = i < 8 ? cl[i] : 300 + $urandom % 2900;
      r = $urandom % 2 ? 32'h30 : 32'h10;
      apb(1'b1, `JLC_OFF_CLK, 32'(c));
      apb(1'b1, `JLC_OFF_RANGE, 32'(r));
      repeat (3) @(posedge clock);
      apb(1'b0, `JLC_OFF_STATUS, 32'h0);
      e = exp_st(c, r);
      chk(rd[5:4], e[1:0]);
      chk(config_error, e[2]);
    end
    apb(1'b1, `JLC_OFF_CLK, 32'hBB8);
    apb(1'b1, `JLC_OFF_RANGE, 32'h30);
    apb(1'b1, `JLC_OFF_CTRL, 32'h1);
    repeat (3) @(posedge clock);
    chk(link_enable, 1'b1);
    s0 = seen;
    repeat (40) @(posedge clock);
    chk(seen - s0, 16'hA);
    per(4);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, ta[i], tv[i]);
      repeat (3) @(posedge clock);
      chk(config_error, te[i]);
      chk(link_enable, !te[i]);
      apb(1'b1, ta[i], ta[i] == 8'h04 ? rv[0] : rv[1]);
    end
    apb(1'b1, `JLC_OFF_RANGE, 32'h10);
    apb(1'b1, `JLC_OFF_DECIM, 32'h6);
    repeat (3) @(posedge clock);
    chk(config_error, 1'b0);
    per(6);
    apb(1'b1, `JLC_OFF_DECIM, 32'h5);
    repeat (3) @(posedge clock);
    chk(config_error, 1'b1);
    // Four converters, eight lanes, one octet: 6000 Mbps at ratio 5
    apb(1'b1, `JLC_OFF_LINK, 32'h11_0148);
    repeat (3) @(posedge clock);
    chk(config_error, 1'b0);
    apb(1'b1, `JLC_OFF_DECIM, 32'h7);
    repeat (3) @(posedge clock);
    chk(config_error, 1'b1);
    give_verdict();
  end
endmodule // jlc_config_select_test
bind jlc_config_select jlc_config_select_chk jlc_config_select_chk_inst (
  .clock, .rst, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .out_sample_en, .link_enable, .config_error);
